// file: core/integrity_cfg.svh
// constants for the system integrity status and interrupt block
`ifndef INTEGRITY_CFG_SVH
`define INTEGRITY_CFG_SVH
`define ICS_ADDR_CTRL 4'h0
`define ICS_ADDR_MASK 4'h1
`define ICS_ADDR_STAT 4'h2
`define ICS_BIT_PAGE 7
`define ICS_BIT_SUPPLY_IE 6
`define ICS_BIT_SUPPLY_FLAG 5
`define ICS_BIT_LV_RESET 4
`define ICS_BIT_RSVD 3
`define ICS_BIT_CLOCK_IE 2
`define ICS_BIT_CLOCK_FLAG 1
`define ICS_BIT_WDG_RESET 0
`define ICS_EV_CLOCK 0
`define ICS_EV_SUPPLY 1
`define ICS_CTRL_RESET 8'h00
`define ICS_MASK_RESET 2'h3
`endif

// file: core/integrity_pkg.sv
// types for the system integrity status and interrupt block
package integrity_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_t;
	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_WAIT = 3'b010,
		PWR_HALT = 3'b100
	} pwr_mode_t;
endpackage : integrity_pkg

// file: core/system_integrity_status_irq.sv
// system integrity page 0 control/status register, event flags and wake-up logic
// Contract
// - Interrupt only when source enable set and cpu interrupt mask clear; irq_o ignores the cpu interrupt mask and follows the mask register.
// - Clock guard event wakes from wait, never from full halt.
// - Clock guard event wakes from active halt.
// - Supply warning stays active in halt and wakes from halt and wait.
// - Bit 7 selects page 0 or page 1 contents.
// - Supply enable in bit 6 requests interrupt on every flag toggle.
// - Bit 5 mirrors supply comparator, written only by hardware.
// - Bit 4 set by hardware on a low voltage reset.
// - Low voltage flag cleared only by writing zero.
// - Low voltage flag undefined when detector disabled by option.
// - Bit 2 enables interrupt once clock guard flag sets.
// - Clock guard interrupt suppressed while backup pll disabled.
// - Reset loads zero except low voltage flag and watchdog flag.
// - Bit 1 set on backup takeover, cleared by read after recovery.
// - Bit 0 set by watchdog reset, cleared by zero write or lv reset.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "integrity_cfg.svh"
module system_integrity_status_irq (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] page1_rdata_i,
	input wire logic cpu_irq_mask_i,
	input wire logic enter_wait_i,
	input wire logic enter_halt_i,
	input wire logic active_halt_i,
	input wire logic backup_pll_enable_i,
	input wire logic supply_cmp_i,
	input wire logic safe_osc_active_i,
	input wire logic osc_recovered_i,
	input wire logic lv_reset_cause_i,
	input wire logic wdg_reset_cause_i,
	input wire logic lvd_option_enabled_i,
	output logic page_sel_o,
	output logic irq_o,
	output logic cpu_irq_o,
	output logic wake_o
);
	integrity_pkg::bus_req_t req;
	integrity_pkg::pwr_mode_t mode_r;
	logic page_r;
	logic supply_ie_r;
	logic supply_flag_r;
	logic lv_flag_r;
	logic clock_ie_r;
	logic clock_flag_r;
	logic wdg_flag_r;
	logic boot_r;
	logic [1:0] stat_r;
	logic [1:0] mask_r;
	logic [1:0] ev_set;
	logic [1:0] pend;
	logic supply_edge;
	logic clock_rise;
	logic clock_prev_r;
	logic pg0_wr;
	logic pg0_rd;
	logic [7:0] ctrl_view;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		hit = (a == b);
	endfunction : hit

	assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
	// page 0 is reached only while the page selector is zero
	assign pg0_wr = req.wr && hit(req.addr, `ICS_ADDR_CTRL) && !page_r;
	assign pg0_rd = req.rd && hit(req.addr, `ICS_ADDR_CTRL) && !page_r;
	// any toggle of the comparator is an event; the boot cycle only loads the
	// flag, so a supply already low at reset release raises no request
	assign supply_edge = (supply_cmp_i != supply_flag_r) && !boot_r;
	// takeover edge of the safe oscillator; ignored while the backup pll is off
	// because the flag must stay cleared then
	assign clock_rise = safe_osc_active_i && !clock_prev_r && backup_pll_enable_i;
	// event strobes feeding the sticky status
	assign ev_set[`ICS_EV_CLOCK] = clock_rise;
	assign ev_set[`ICS_EV_SUPPLY] = supply_edge;
	assign ctrl_view = {page_r, supply_ie_r, supply_flag_r, lv_flag_r, 1'b0,
		clock_ie_r, clock_flag_r, wdg_flag_r};
	// pending requests: clock flag or supply status bit with enable; clock guard gated by pll enable
	assign pend[`ICS_EV_CLOCK] = clock_flag_r && clock_ie_r && backup_pll_enable_i;
	assign pend[`ICS_EV_SUPPLY] = stat_r[`ICS_EV_SUPPLY] && supply_ie_r;

	// ----------------------------------------------------------------
	// control register bits
	// ----------------------------------------------------------------
	// page selector, software read/write, cleared by reset
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			page_r <= 1'b0;
		else if (ce_i && req.wr && hit(req.addr, `ICS_ADDR_CTRL))
			page_r <= req.wdata[`ICS_BIT_PAGE];
	end

	// interrupt enables; ignored while page 1 is selected, since the same
	// address then reaches the pll and clock select fields
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			supply_ie_r <= 1'b0;
			clock_ie_r <= 1'b0;
		end
		else if (ce_i && pg0_wr)
		begin
			supply_ie_r <= req.wdata[`ICS_BIT_SUPPLY_IE];
			clock_ie_r <= req.wdata[`ICS_BIT_CLOCK_IE];
		end
	end

	// ----------------------------------------------------------------
	// reset causes and status flags
	// ----------------------------------------------------------------
	// first cycle after reset: latch reset causes and comparator
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			boot_r <= 1'b1;
		else if (ce_i)
			boot_r <= 1'b0;
	end

	// supply flag mirrors the comparator, writes ignored
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			supply_flag_r <= 1'b0;
		else if (ce_i)
			supply_flag_r <= supply_cmp_i;
	end

	// low voltage reset flag: set at release, cleared only by zero write.
	// it has no reset branch on purpose: a watchdog or pin reset must leave it
	// as it was, so the cause of an earlier supply failure is not lost.
	// its power-up value is only known once a low voltage reset with the detector option enabled, or a zero write to bit 4, has occurred.
	always_ff @(posedge clk_i)
	begin
		if (resetn_i && ce_i && boot_r)
			lv_flag_r <= (lv_reset_cause_i && lvd_option_enabled_i) | lv_flag_r;
		else if (resetn_i && ce_i && pg0_wr && !req.wdata[`ICS_BIT_LV_RESET])
			lv_flag_r <= 1'b0;
	end

	// watchdog reset flag: set by watchdog, cleared by zero write or lv reset
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			wdg_flag_r <= 1'b0;
		else if (ce_i && boot_r)
			wdg_flag_r <= wdg_reset_cause_i && !lv_reset_cause_i;
		else if (ce_i && pg0_wr && !req.wdata[`ICS_BIT_WDG_RESET])
			wdg_flag_r <= 1'b0;
	end

	// clock guard flag: set on takeover, read clears once oscillator recovered
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			clock_flag_r <= 1'b0;
			clock_prev_r <= 1'b0;
		end
		else if (ce_i)
		begin
			clock_prev_r <= safe_osc_active_i;
			if (!backup_pll_enable_i)
				clock_flag_r <= 1'b0;
			else if (clock_rise)
				clock_flag_r <= 1'b1;
			else if (pg0_rd && osc_recovered_i)
				clock_flag_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	// sticky status: set wins over read-clear; clock bit tracks its pending request,
	// since the clock flag has its own clear on a control register read
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			stat_r <= 2'h0;
		else if (ce_i)
		begin
			stat_r[`ICS_EV_CLOCK] <= pend[`ICS_EV_CLOCK] | ev_set[`ICS_EV_CLOCK];
			if (ev_set[`ICS_EV_SUPPLY])
				stat_r[`ICS_EV_SUPPLY] <= 1'b1;
			else if (req.rd && hit(req.addr, `ICS_ADDR_STAT))
				stat_r[`ICS_EV_SUPPLY] <= 1'b0;
		end
	end

	// interrupt mask register, one bit per event in the status layout;
	// reachable on either page since it sits at its own address
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			mask_r <= `ICS_MASK_RESET;
		else if (ce_i && req.wr && hit(req.addr, `ICS_ADDR_MASK))
			mask_r <= req.wdata[1:0];
	end

	// interrupt outputs: held level while cause and enable stand;
	// irq_o answers the mask register, cpu_irq_o the cpu interrupt mask
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			irq_o <= 1'b0;
			cpu_irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			irq_o <= |(pend & mask_r);
			cpu_irq_o <= (|pend) && !cpu_irq_mask_i;
		end
	end

	// ----------------------------------------------------------------
	// low power mode tracking and wake-up
	// ----------------------------------------------------------------
	// wait wakes on any pending request; halt only on the supply warning,
	// or on the clock guard as well when the halt is an active halt
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			mode_r <= integrity_pkg::PWR_RUN;
			wake_o <= 1'b0;
		end
		else if (ce_i)
		begin
			wake_o <= 1'b0;
			case (mode_r)
				integrity_pkg::PWR_RUN:
				begin
					if (enter_halt_i)
						mode_r <= integrity_pkg::PWR_HALT;
					else if (enter_wait_i)
						mode_r <= integrity_pkg::PWR_WAIT;
				end
				integrity_pkg::PWR_WAIT:
				begin
					if (|pend)
					begin
						mode_r <= integrity_pkg::PWR_RUN;
						wake_o <= 1'b1;
					end
				end
				integrity_pkg::PWR_HALT:
				begin
					// full halt: only supply warning; active halt: clock guard too
					if (pend[`ICS_EV_SUPPLY] || (active_halt_i && pend[`ICS_EV_CLOCK]))
					begin
						mode_r <= integrity_pkg::PWR_RUN;
						wake_o <= 1'b1;
					end
				end
				default:
					mode_r <= integrity_pkg::PWR_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------------------------------
	// zero outside the read slot and for unmapped addresses, so a bus
	// that ors several slaves together needs no extra gating
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			rdata_o <= 8'h00;
		else if (ce_i && req.rd)
		begin
			if (hit(req.addr, `ICS_ADDR_CTRL))
				rdata_o <= page_r ? page1_rdata_i : ctrl_view;
			else if (hit(req.addr, `ICS_ADDR_MASK))
				rdata_o <= {6'h00, mask_r};
			else if (hit(req.addr, `ICS_ADDR_STAT))
				rdata_o <= {6'h00, stat_r};
			else
				rdata_o <= 8'h00;
		end
		else if (ce_i)
			rdata_o <= 8'h00;
	end

	// page selector goes out to the page 1 register bank
	assign page_sel_o = page_r;
endmodule : system_integrity_status_irq
`default_nettype wire

// file: tb/integrity_checker.sv
// port-level assertions for the system integrity status and interrupt block
`timescale 1ns/100ps
`default_nettype none
module integrity_checker (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] page1_rdata_i,
	input wire logic cpu_irq_mask_i,
	input wire logic backup_pll_enable_i,
	input wire logic lvd_option_enabled_i,
	input wire logic page_sel_o,
	input wire logic cpu_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// page 0 read and all-zero write of the control register
	sequence s_rd0; ce_i && rd_i && addr_i == 4'h0 && !page_sel_o; endsequence
	sequence s_wr0; ce_i && wr_i && addr_i == 4'h0 && !page_sel_o && wdata_i == 8'h00; endsequence
	property p_cpu_mask; ce_i && cpu_irq_mask_i |=> !cpu_irq_o; endproperty
	a_cpu_mask: assert property (p_cpu_mask)
		else $error("cpu request while masked");
	property p_cpu_rose; $rose(cpu_irq_o) |-> !$past(cpu_irq_mask_i); endproperty
	a_cpu_rose: assert property (p_cpu_rose)
		else $error("cpu request rose under mask");
	property p_page_wr; ce_i && wr_i && addr_i == 4'h0 |=> page_sel_o == $past(wdata_i[7]); endproperty
	a_page_wr: assert property (p_page_wr)
		else $error("page bit not written");
	property p_page1_rd;
		ce_i && rd_i && addr_i == 4'h0 && page_sel_o |=> rdata_o == $past(page1_rdata_i);
	endproperty
	a_page1_rd: assert property (p_page1_rd)
		else $error("page 1 read wrong");
	property p_rd_idle; ce_i && !rd_i |=> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	property p_rsvd; s_rd0 |=> !rdata_o[3]; endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bit reads one");
	property p_pll_off; !backup_pll_enable_i ##1 !backup_pll_enable_i ##0 s_rd0 |=> !rdata_o[1]; endproperty
	a_pll_off: assert property (p_pll_off)
		else $error("clock flag set with pll off");
	property p_lv_clr; lvd_option_enabled_i ##0 s_wr0 ##1 s_rd0 |=> !rdata_o[4]; endproperty
	a_lv_clr: assert property (p_lv_clr)
		else $error("low voltage flag not cleared");
	property p_wdg_clr; s_wr0 ##1 s_rd0 |=> !rdata_o[0]; endproperty
	a_wdg_clr: assert property (p_wdg_clr)
		else $error("watchdog flag not cleared");
endmodule : integrity_checker
bind system_integrity_status_irq integrity_checker integrity_checker_inst (.clk_i, .resetn_i,
	.ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .page1_rdata_i, .cpu_irq_mask_i,
	.backup_pll_enable_i, .lvd_option_enabled_i, .page_sel_o, .cpu_irq_o);
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the system integrity status and interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic cpu_irq_mask_i = 1'b1, enter_wait_i = 1'b0, enter_halt_i = 1'b0, active_halt_i = 1'b0;
	logic backup_pll_enable_i = 1'b0, supply_cmp_i = 1'b0, safe_osc_active_i = 1'b0;
	logic osc_recovered_i = 1'b0, lv_reset_cause_i = 1'b1, wdg_reset_cause_i = 1'b1;
	logic lvd_option_enabled_i = 1'b1, page_sel_o, irq_o, cpu_irq_o, wake_o;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, page1_rdata_i = 8'h00, rdata_o, p, w;
	int n_errors = 0, checked = 0;
	// 125 MHz clock
	always #4 clk_i = ~clk_i;
	system_integrity_status_irq system_integrity_status_irq_inst (.clk_i, .resetn_i, .ce_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .page1_rdata_i, .cpu_irq_mask_i, .enter_wait_i,
		.enter_halt_i, .active_halt_i, .backup_pll_enable_i, .supply_cmp_i, .safe_osc_active_i,
		.osc_recovered_i, .lv_reset_cause_i, .wdg_reset_cause_i, .lvd_option_enabled_i,
		.page_sel_o, .irq_o, .cpu_irq_o, .wake_o);
	// only the two enables survive a page 0 write
	function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
		return v & 8'h44;
	endfunction : exp_ctrl
	function automatic logic sg(input int k);
		return k == 0 ? irq_o : k == 1 ? cpu_irq_o : wake_o;
	endfunction : sg
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic ck(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			n_errors++;
		end
	endtask : ck
	// bus tasks start and end just after a rising edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		if (n != "")
			ck(n, e, rdata_o);
		@(posedge clk_i);
	endtask : rc
	// bounded wait for an output level, sampled mid-cycle
	task automatic wt(input string n, input int k, input logic v);
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk_i);
			if (sg(k) === v)
				break;
		end
		ck(n, {7'h00, v}, {7'h00, sg(k)});
		if (sg(k) !== v)
			tally_and_finish();
		@(posedge clk_i);
	endtask : wt
	task automatic nw(input string n, input int k);
		repeat (8)
		begin
			@(negedge clk_i);
			ck(n, 8'h00, {7'h00, sg(k)});
		end
		@(posedge clk_i);
	endtask : nw
	task automatic mode(input logic h);
		enter_halt_i <= h;
		enter_wait_i <= !h;
		@(posedge clk_i);
		enter_halt_i <= 1'b0;
		enter_wait_i <= 1'b0;
	endtask : mode
	// mid-run reset with the given causes, returns just after the boot edge
	task automatic rst(input logic lv, input logic wd);
		lv_reset_cause_i <= lv;
		wdg_reset_cause_i <= wd;
		resetn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
	endtask : rst
	task automatic cl();
		safe_osc_active_i <= 1'b0;
		rc("", 4'h0, 8'h00);
		rc("", 4'h2, 8'h00);
	endtask : cl
	// main sequence
	initial
	begin
		void'($urandom(32'h7a9a));
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		rc("ctrl reset", 4'h0, 8'h10);
		rc("mask reset", 4'h1, 8'h03);
		rc("unmapped", 4'hf, 8'h00);
		wr(4'h0, 8'h2a);
		rc("ro bits", 4'h0, 8'h00);
		rst(1'b0, 1'b1);
		rc("wdg cause", 4'h0, 8'h01);
		rst(1'b1, 1'b1);
		rc("lv cause", 4'h0, 8'h10);
		rst(1'b0, 1'b1);
		rc("lv kept", 4'h0, 8'h11);
		wr(4'h0, 8'h00);
		rc("lv clear", 4'h0, 8'h00);
		rst(1'b0, 1'b0);
		rc("pin cause", 4'h0, 8'h00);
		$display("test reset done");
		wr(4'h1, 8'h01);
		rc("mask wr", 4'h1, 8'h01);
		wr(4'h0, 8'h40);
		supply_cmp_i <= 1'b1;
		nw("mask blocks", 0);
		nw("cpu masked", 1);
		wr(4'h1, 8'h03);
		wt("supply irq", 0, 1'b1);
		cpu_irq_mask_i <= 1'b0;
		wt("cpu irq", 1, 1'b1);
		rc("flag up", 4'h0, 8'h60);
		rc("stat", 4'h2, 8'h02);
		wt("irq clr", 0, 1'b0);
		supply_cmp_i <= 1'b0;
		wt("fall irq", 0, 1'b1);
		rc("stat fall", 4'h2, 8'h02);
		wt("irq clr fall", 0, 1'b0);
		$display("test supply done");
		wr(4'h0, 8'h04);
		safe_osc_active_i <= 1'b1;
		nw("pll off", 0);
		rc("flag held", 4'h0, 8'h04);
		backup_pll_enable_i <= 1'b1;
		safe_osc_active_i <= 1'b0;
		@(posedge clk_i);
		safe_osc_active_i <= 1'b1;
		wt("clock irq", 0, 1'b1);
		rc("flag set", 4'h0, 8'h06);
		rc("stat clock", 4'h2, 8'h01);
		safe_osc_active_i <= 1'b0;
		osc_recovered_i <= 1'b1;
		rc("flag rd", 4'h0, 8'h06);
		rc("flag clr", 4'h0, 8'h04);
		wt("irq off", 0, 1'b0);
		$display("test clock done");
		repeat (4)
		begin
			p = 8'($urandom);
			w = exp_ctrl(8'($urandom));
			page1_rdata_i <= p;
			wr(4'h0, {1'b1, w[6:0]});
			rc("page1", 4'h0, p);
			wr(4'h0, 8'h00);
			rc("page0", 4'h0, w);
		end
		// a write while the clock enable is low must not land
		ce_i <= 1'b0;
		wr(4'h1, 8'h00);
		ce_i <= 1'b1;
		rc("ce freeze", 4'h1, 8'h03);
		$display("test page done");
		wr(4'h0, 8'h44);
		mode(1'b1);
		safe_osc_active_i <= 1'b1;
		nw("halt clock", 2);
		supply_cmp_i <= 1'b1;
		wt("halt supply", 2, 1'b1);
		cl();
		mode(1'b0);
		safe_osc_active_i <= 1'b1;
		wt("wait clock", 2, 1'b1);
		cl();
		active_halt_i <= 1'b1;
		mode(1'b1);
		safe_osc_active_i <= 1'b1;
		wt("active halt", 2, 1'b1);
		$display("test wake done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
